// ==== csq_pkg.sv ====
// Purpose: Shared constants for the charge sequencer and power selector
// Assumes: 125 MHz pclk, APB register access
// Notes: Long counts are top-level parameters that a bench may shorten
package csq_pkg;
  localparam int CLK_MHZ = 125;
  // Timing figures in their own units
  localparam int PWRUP_DLY_MS = 30;
  localparam int DEAD_TIME_US = 10;
  localparam int SS_STEP_US = 1600;
  localparam int PRECHG_TMO_MIN = 30;
  localparam int CE_DLY_MS = 1500;
  localparam int TMR_TENTH_MIN_PER_NF = 56;
  localparam int SS_STEPS = 8;
  // Derived cycle counts
  localparam longint PWRUP_DLY_CYC = longint'(PWRUP_DLY_MS) * 1000 * CLK_MHZ;
  localparam int DEAD_TIME_CYC = DEAD_TIME_US * CLK_MHZ;
  localparam longint SS_STEP_CYC = longint'(SS_STEP_US) * CLK_MHZ;
  localparam longint PRECHG_TMO_CYC = longint'(PRECHG_TMO_MIN) * 60 * 1000000 * CLK_MHZ;
  localparam longint CE_DLY_CYC = longint'(CE_DLY_MS) * 1000 * CLK_MHZ;
  // Cycles per tenth of a minute, used for safety time per nF
  localparam longint TENTH_MIN_CYC = longint'(6) * 1000000 * CLK_MHZ;
  // Register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] CAP_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  // Control field positions
  localparam int CTRL_CE_BIT = 0;
  localparam int CTRL_TMR_MODE_LSB = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] CAP_NF_RST = 8'h32;
  // Timer pin modes
  typedef enum logic [1:0] {
    CSQ_TMR_CAP = 2'b00,
    CSQ_TMR_LOW = 2'b01,
    CSQ_TMR_REF = 2'b10
  } csq_tmr_mode_t;
  // Charge states, Gray along the usual path
  typedef enum logic [2:0] {
    CSQ_IDLE = 3'b000,
    CSQ_PRE = 3'b001,
    CSQ_FAST = 3'b011,
    CSQ_DONE = 3'b010,
    CSQ_FAULT = 3'b110
  } csq_chg_t;
  // Selector states
  typedef enum logic [1:0] {
    CSQ_SEL_BAT = 2'b00,
    CSQ_SEL_DEAD_AC = 2'b01,
    CSQ_SEL_AC = 2'b11,
    CSQ_SEL_DEAD_BAT = 2'b10
  } csq_sel_t;
  // Status codes on the two status outputs
  localparam logic [1:0] STAT_CHARGING = 2'b01;
  localparam logic [1:0] STAT_DONE = 2'b10;
  localparam logic [1:0] STAT_FAULT = 2'b11;
  localparam logic [1:0] STAT_OFF = 2'b00;
endpackage : csq_pkg

// ==== csq_timer.sv ====
// Purpose: Clearable up-counter with a done flag
// Assumes: Limit is held steady while the counter runs
// Notes: Stops at the limit, done stays high until cleared
`timescale 1ns/1ps
module csq_timer #(
  parameter int W = 40
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clr,
  input wire logic run,
  input wire logic [W-1:0] limit,
  // Result
  output logic done
);
  logic [W-1:0] cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (clr) begin
      cnt_ff <= '0;
    end else if (run && cnt_ff < limit) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
    end else if (clr) begin
      done <= 1'b0;
    end else if (run && cnt_ff + 1'b1 >= limit) begin
      done <= 1'b1;
    end
  end
endmodule : csq_timer

// ==== csq_top.sv ====
// Purpose: Charge sequencer and system power selector control core
// Assumes: Comparator flags synchronous to pclk, APB register access
// Notes: Analog loops are outside; outputs are levels and a current target
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
// How it works
// - Low battery at start selects precharge
// - Precharge beyond 30 minutes gives fault
// - Terminate on high feedback, low current
// - Safety time is capacitance times 5.6 min/nF
// - Recharge, reset or enable toggle restart
// - Timer pin low disables termination, timer
// - Timer pin at reference disables timer
// - Supply faults recovering reset safety timer
// - Adapter above battery selects adapter switch
// - Battery above supply: battery, sleep
// - Undervoltage: adapter off, battery on
// - Charge only when all conditions good
// - Any stop condition ends charging
// - Battery connected at power-up, sleep
// - 30 ms after sleep exit, switch adapter
// - 10 us dead time before adapter on
// - Back to battery within 200 mV
// - Fast charge ramps in eight steps
// - Charging waits 1.5 s after enable
module csq_top
  import csq_pkg::*;
#(
  parameter longint PWRUP_CYC = csq_pkg::PWRUP_DLY_CYC,
  parameter longint SS_CYC = csq_pkg::SS_STEP_CYC,
  parameter longint PRE_TMO_CYC = csq_pkg::PRECHG_TMO_CYC,
  parameter longint CE_CYC = csq_pkg::CE_DLY_CYC,
  parameter longint TMIN_CYC = csq_pkg::TENTH_MIN_CYC,
  parameter int ISET_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparator flags
  input wire logic supply_above_batt,
  input wire logic supply_near_batt,
  input wire logic undervoltage_lockout,
  input wire logic low_supply_state,
  input wire logic input_overvoltage,
  input wire logic regulators_good,
  input wire logic die_overtemp,
  input wire logic battery_temp_fault,
  input wire logic battery_low,
  input wire logic below_recharge,
  input wire logic fb_above_recharge,
  input wire logic current_below_term,
  input wire logic voltage_reg_phase,
  // Charge programming
  input wire logic [ISET_W-1:0] fast_current,
  input wire logic [ISET_W-1:0] pre_current,
  // Outputs
  output logic adapter_switch_drive,
  output logic battery_switch_drive,
  output logic sleep_mode,
  output logic charge_on,
  output logic [ISET_W-1:0] current_target,
  output logic status_out_a,
  output logic status_out_b
);
  import csq_pkg::*;
  localparam int TW = 48;

  logic ce_ff;
  csq_tmr_mode_t tmr_mode_ff;
  logic [7:0] cap_nf_ff;
  csq_chg_t chg_ff;
  csq_sel_t sel_ff;
  logic ce_prev_ff;
  logic fault_prev_ff;
  logic [2:0] step_ff;
  logic [1:0] nxt_stat;
  logic [TW-1:0] ss_cnt_ff;
  logic [$clog2(DEAD_TIME_CYC+1)-1:0] dead_cnt_ff;

  // APB, zero wait states
  wire logic apb_acc = psel && penable;
  wire logic apb_wr = apb_acc && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_ff <= CTRL_RST[CTRL_CE_BIT];
      tmr_mode_ff <= CSQ_TMR_CAP;
      cap_nf_ff <= CAP_NF_RST;
    end else if (apb_wr && paddr == CTRL_OFS) begin
      ce_ff <= pwdata[CTRL_CE_BIT];
      tmr_mode_ff <= csq_tmr_mode_t'(pwdata[CTRL_TMR_MODE_LSB+:2]);
    end else if (apb_wr && paddr == CAP_OFS) begin
      cap_nf_ff <= pwdata[7:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == CTRL_OFS || paddr == CAP_OFS || paddr == STAT_OFS);
      case (paddr)
        CTRL_OFS: prdata <= {29'h0, tmr_mode_ff, ce_ff};
        CAP_OFS: prdata <= {24'h0, cap_nf_ff};
        STAT_OFS: prdata <= {22'h0, nxt_stat, step_ff, sel_ff, chg_ff};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // sleep when battery powers the supply
  wire logic sleep_now = !supply_above_batt && !undervoltage_lockout;
  wire logic supply_bad = undervoltage_lockout || low_supply_state || sleep_now || input_overvoltage;
  wire logic supply_recover = fault_prev_ff && !supply_bad;
  wire logic ce_toggle = ce_ff != ce_prev_ff;
  wire logic restart = ce_toggle || (chg_ff == CSQ_DONE && below_recharge);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_prev_ff <= 1'b0;
      fault_prev_ff <= 1'b0;
    end else begin
      ce_prev_ff <= ce_ff;
      fault_prev_ff <= supply_bad;
    end
  end

  logic pwrup_done;
  logic ce_dly_done;
  logic pre_tmo;
  logic safety_done;
  logic dly30_done;
  csq_timer #(.W(TW)) u_pwrup (
    .pclk(pclk), .presetn(presetn), .clr(1'b0), .run(1'b1),
    .limit(TW'(PWRUP_CYC)), .done(pwrup_done)
  );
  csq_timer #(.W(TW)) u_ce_dly (
    .pclk(pclk), .presetn(presetn), .clr(!ce_ff), .run(ce_ff),
    .limit(TW'(CE_CYC)), .done(ce_dly_done)
  );
  csq_timer #(.W(TW)) u_pre (
    .pclk(pclk), .presetn(presetn), .clr(chg_ff != CSQ_PRE), .run(1'b1),
    .limit(TW'(PRE_TMO_CYC)), .done(pre_tmo)
  );
  wire logic [TW-1:0] safety_lim = TW'(TMIN_CYC * TMR_TENTH_MIN_PER_NF) * TW'(cap_nf_ff);
  wire logic timer_used = tmr_mode_ff == CSQ_TMR_CAP;
  wire logic chg_active = chg_ff == CSQ_PRE || chg_ff == CSQ_FAST;
  // timer pin low holds timer in reset
  wire logic safety_clr = restart || supply_recover || tmr_mode_ff == CSQ_TMR_LOW;
  csq_timer #(.W(TW)) u_safety (
    .pclk(pclk), .presetn(presetn), .clr(safety_clr), .run(timer_used && chg_active),
    .limit(safety_lim), .done(safety_done)
  );
  csq_timer #(.W(TW)) u_sleep_exit (
    .pclk(pclk), .presetn(presetn), .clr(sleep_now || undervoltage_lockout), .run(1'b1),
    .limit(TW'(PWRUP_CYC)), .done(dly30_done)
  );

  wire logic chg_ok = ce_ff && !supply_bad && regulators_good && !die_overtemp &&
    !battery_temp_fault && pwrup_done && ce_dly_done && sel_ff == CSQ_SEL_AC;
  // termination only when timer pin allows
  wire logic term_hit = voltage_reg_phase && tmr_mode_ff != CSQ_TMR_LOW &&
    fb_above_recharge && current_below_term;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_ff <= CSQ_IDLE;
    end else begin
      case (chg_ff)
        CSQ_IDLE: begin
          if (chg_ok) begin
            chg_ff <= battery_low ? CSQ_PRE : CSQ_FAST;
          end
        end
        CSQ_PRE: begin
          if (!chg_ok) begin
            chg_ff <= CSQ_IDLE;
          end else if (pre_tmo) begin
            chg_ff <= CSQ_FAULT;
          end else if (!battery_low) begin
            chg_ff <= CSQ_FAST;
          end
        end
        CSQ_FAST: begin
          if (!chg_ok) begin
            chg_ff <= CSQ_IDLE;
          end else if (safety_done) begin
            chg_ff <= CSQ_FAULT;
          end else if (term_hit) begin
            chg_ff <= CSQ_DONE;
          end
        end
        CSQ_DONE: begin
          if (restart || !chg_ok) begin
            chg_ff <= CSQ_IDLE;
          end
        end
        CSQ_FAULT: begin
          if (restart) begin
            chg_ff <= CSQ_IDLE;
          end
        end
        default: chg_ff <= CSQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_ff <= 3'h0;
      ss_cnt_ff <= '0;
    end else if (chg_ff != CSQ_FAST) begin
      step_ff <= 3'h0;
      ss_cnt_ff <= '0;
    end else if (step_ff != 3'(SS_STEPS - 1)) begin
      if (ss_cnt_ff >= TW'(SS_CYC - 1)) begin
        ss_cnt_ff <= '0;
        step_ff <= step_ff + 3'h1;
      end else begin
        ss_cnt_ff <= ss_cnt_ff + 1'b1;
      end
    end
  end
  // Product kept wide, full scale reached on last step
  wire logic [ISET_W+3:0] ramp = (ISET_W+4)'(fast_current) * (ISET_W+4)'({1'b0, step_ff} + 4'h1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_target <= '0;
      charge_on <= 1'b0;
    end else begin
      // Falls with the stop condition, not a cycle behind it
      charge_on <= chg_active && chg_ok;
      case (chg_ff)
        CSQ_PRE: current_target <= pre_current;
        CSQ_FAST: current_target <= ISET_W'(ramp >> 3);
        default: current_target <= '0;
      endcase
    end
  end

  // Selector; near-battery flag gates return path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff <= CSQ_SEL_BAT;
      dead_cnt_ff <= '0;
    end else begin
      case (sel_ff)
        CSQ_SEL_BAT: begin
          dead_cnt_ff <= '0;
          if (supply_above_batt && !undervoltage_lockout && !input_overvoltage && dly30_done) begin
            sel_ff <= CSQ_SEL_DEAD_AC;
          end
        end
        CSQ_SEL_DEAD_AC: begin
          if (undervoltage_lockout || !supply_above_batt) begin
            sel_ff <= CSQ_SEL_BAT;
          end else if (dead_cnt_ff == DEAD_TIME_CYC - 1) begin
            sel_ff <= CSQ_SEL_AC;
          end else begin
            dead_cnt_ff <= dead_cnt_ff + 1'b1;
          end
        end
        CSQ_SEL_AC: begin
          dead_cnt_ff <= '0;
          // lockout at once, otherwise via dead time
          if (undervoltage_lockout) begin
            sel_ff <= CSQ_SEL_BAT;
          end else if (supply_near_batt || input_overvoltage) begin
            sel_ff <= CSQ_SEL_DEAD_BAT;
          end
        end
        CSQ_SEL_DEAD_BAT: begin
          if (undervoltage_lockout) begin
            sel_ff <= CSQ_SEL_BAT;
          end else if (dead_cnt_ff == DEAD_TIME_CYC - 1) begin
            sel_ff <= CSQ_SEL_BAT;
          end else begin
            dead_cnt_ff <= dead_cnt_ff + 1'b1;
          end
        end
        default: sel_ff <= CSQ_SEL_BAT;
      endcase
    end
  end

  // battery on in reset, sleep; lockout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adapter_switch_drive <= 1'b0;
      battery_switch_drive <= 1'b1;
      sleep_mode <= 1'b1;
    end else begin
      adapter_switch_drive <= sel_ff == CSQ_SEL_AC && !undervoltage_lockout;
      // Adapter is forced off on the same edge, so no overlap
      battery_switch_drive <= sel_ff == CSQ_SEL_BAT || undervoltage_lockout;
      sleep_mode <= sleep_now;
    end
  end

  always_comb begin
    case (chg_ff)
      CSQ_PRE, CSQ_FAST: nxt_stat = STAT_CHARGING;
      CSQ_DONE: nxt_stat = STAT_DONE;
      CSQ_FAULT: nxt_stat = STAT_FAULT;
      default: nxt_stat = STAT_OFF;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_out_a <= 1'b0;
      status_out_b <= 1'b0;
    end else begin
      status_out_a <= nxt_stat[0];
      status_out_b <= nxt_stat[1];
    end
  end
endmodule : csq_top

// ==== csq_partner.sv ====
// Purpose: Adapter and cell model
// Assumes: Cell fills one count per charging cycle
// Notes: Rail sags slowly after unplug
`timescale 1ns/1ps
module csq_partner (
  // Clock
  input wire logic pclk,
  // Bench controls
  input wire logic plugged,
  input wire logic dead_cell,
  input wire logic charge_on,
  // Comparator flags
  output logic supply_above_batt,
  output logic supply_near_batt,
  output logic battery_low,
  output logic below_recharge,
  output logic fb_above_recharge,
  output logic current_below_term,
  output logic voltage_reg_phase
);
  int lvl = 0;
  // Starts unplugged with the rail long since down
  int sag = 100;
  always @(posedge pclk) begin
    if (charge_on && !dead_cell && lvl < 400) lvl <= lvl + 1;
    // Input caps hold the rail for a while
    sag <= plugged ? 0 : sag + 1;
  end
  assign supply_near_batt = !plugged && sag > 40;
  assign supply_above_batt = !supply_near_batt;
  assign battery_low = lvl < 20;
  assign below_recharge = lvl < 250;
  assign voltage_reg_phase = lvl > 300;
  assign fb_above_recharge = lvl > 300;
  assign current_below_term = lvl > 350;
endmodule : csq_partner

// ==== csq_assertions.sv ====
// Purpose: Port checks for csq_top
// Assumes: One clock domain
// Notes: Dead time counted in helper logic
`timescale 1ns/1ps
module csq_assertions
  import csq_pkg::*;
#(
  parameter int ISET_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Flags
  input wire logic supply_above_batt,
  input wire logic undervoltage_lockout,
  input wire logic input_overvoltage,
  input wire logic [ISET_W-1:0] fast_current,
  input wire logic [ISET_W-1:0] pre_current,
  // Outputs
  input wire logic adapter_switch_drive,
  input wire logic battery_switch_drive,
  input wire logic sleep_mode,
  input wire logic charge_on,
  input wire logic [ISET_W-1:0] current_target,
  input wire logic status_out_a,
  input wire logic status_out_b
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [11:0] off_cnt_ff;
  // Saturates so a long idle never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) off_cnt_ff <= 12'h000;
    else if (adapter_switch_drive || battery_switch_drive) off_cnt_ff <= 12'h000;
    else if (off_cnt_ff != 12'hfff) off_cnt_ff <= off_cnt_ff + 12'h001;
  end
  a_no_overlap: assert property (!(adapter_switch_drive && battery_switch_drive))
    else $error("both switches on");
  a_ac_dead_time: assert property ($rose(adapter_switch_drive) |-> off_cnt_ff >= 12'h4e2)
    else $error("adapter dead time short");
  a_bat_dead_time: assert property ($rose(battery_switch_drive) && !undervoltage_lockout
    && !input_overvoltage |-> off_cnt_ff >= 12'h4e2) else $error("battery dead time short");
  a_sleep_keeps_bat: assert property (sleep_mode && battery_switch_drive |=> battery_switch_drive)
    else $error("battery dropped in sleep");
  a_sleep_entry: assert property (!supply_above_batt [*4] |-> sleep_mode)
    else $error("no sleep on battery");
  a_sleep_no_chg: assert property (sleep_mode |-> !charge_on)
    else $error("charging in sleep");
  a_chg_needs_ac: assert property ($rose(charge_on) |-> adapter_switch_drive)
    else $error("charge without adapter");
  a_ov_stop: assert property ($rose(input_overvoltage) |-> ##[1:3] !charge_on)
    else $error("overvoltage kept charging");
  a_lockout_switch: assert property ($rose(undervoltage_lockout) |->
    ##[1:3] (!adapter_switch_drive && battery_switch_drive)) else $error("lockout switches wrong");
  a_fault_idle: assert property ({status_out_b, status_out_a} == STAT_FAULT |-> !charge_on)
    else $error("charging in fault");
  a_target_cap: assert property (charge_on |-> current_target <= fast_current
    || current_target == pre_current) else $error("target above setting");
endmodule : csq_assertions

bind csq_top csq_assertions #(.ISET_W(ISET_W)) chk_u (.pclk(pclk), .presetn(presetn),
  .supply_above_batt(supply_above_batt), .undervoltage_lockout(undervoltage_lockout),
  .input_overvoltage(input_overvoltage), .fast_current(fast_current), .pre_current(pre_current),
  .adapter_switch_drive(adapter_switch_drive), .battery_switch_drive(battery_switch_drive),
  .sleep_mode(sleep_mode), .charge_on(charge_on), .current_target(current_target),
  .status_out_a(status_out_a), .status_out_b(status_out_b));

// ==== charge_sequencer_power_selector_test.sv ====
// Purpose: Self-checking bench for csq_top
// Assumes: Shortened counts, dead time 1250 cycles
// Notes: Cell and adapter come from csq_partner
`timescale 1ns/1ps
module charge_sequencer_power_selector_test;
  import csq_pkg::*;
  typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} csq_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sab, snb, blow, brc, fbr, cbt, vrp, ac, bat, slp, chg, sa, sb;
  logic plugged = 1'b0, dead_cell = 1'b1, lockout = 1'b0, ovp = 1'b0;
  logic lss = 1'b0, rgood = 1'b1, dot = 1'b0, btf = 1'b0;
  logic [7:0] tgt;
  logic [7:0] fast_i = 8'ha0;
  logic [7:0] pre_i = 8'h08;
  int n_mismatch = 0, compares = 0, cyc = 0;
  csq_row_t rows[7] = '{'{0, 12'h004, 0, 32'h32, 0}, '{0, 12'h000, 0, 0, 0},
    '{1, 12'h004, 32'h2, 0, 0}, '{0, 12'h004, 0, 32'h2, 0}, '{1, 12'h000, 32'h4, 0, 0},
    '{0, 12'h000, 0, 32'h4, 0}, '{0, 12'h00c, 0, 0, 1}};
  always #4 pclk = ~pclk;
  csq_top #(.PWRUP_CYC(50), .SS_CYC(4), .PRE_TMO_CYC(200), .CE_CYC(30), .TMIN_CYC(1)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_above_batt(sab), .supply_near_batt(snb), .undervoltage_lockout(lockout),
    .low_supply_state(lss), .input_overvoltage(ovp), .regulators_good(rgood), .die_overtemp(dot),
    .battery_temp_fault(btf), .battery_low(blow), .below_recharge(brc), .fb_above_recharge(fbr),
    .current_below_term(cbt), .voltage_reg_phase(vrp), .fast_current(fast_i), .pre_current(pre_i),
    .adapter_switch_drive(ac), .battery_switch_drive(bat), .sleep_mode(slp), .charge_on(chg),
    .current_target(tgt), .status_out_a(sa), .status_out_b(sb));
  csq_partner pm_u (.pclk(pclk), .plugged(plugged), .dead_cell(dead_cell), .charge_on(chg),
    .supply_above_batt(sab), .supply_near_batt(snb), .battery_low(blow), .below_recharge(brc),
    .fb_above_recharge(fbr), .current_below_term(cbt), .voltage_reg_phase(vrp));
  task automatic end_sim;
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Bench timeout ends a hang here
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wt(input string nm, ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(nm, v, s);
  endtask : wt
  task automatic wstat(input logic [1:0] x, input int lim);
    int n;
    n = 0;
    while ({sb, sa} !== x && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk("status", x, {sb, sa});
  endtask : wstat
  task automatic ctrl(input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, 12'h000, d, q, e);
  endtask : ctrl
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    logic [31:0] q;
    logic e;
    int n;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("bat", 1, bat);
    chk("sleep", 1, slp);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d, q, e);
      chk("err", rows[i].e, e);
      if (!rows[i].wr) chk("rdata", rows[i].q, q);
    end
    plugged <= 1'b1;
    repeat (40) @(posedge pclk);
    chk("ac early", 0, ac);
    wt("ac on", ac, 1'b1, 1400);
    chk("bat off", 0, bat);
    ctrl(32'h5);
    repeat (20) @(posedge pclk);
    chk("ce delay", 0, chg);
    wt("pre on", chg, 1'b1, 100);
    @(posedge pclk);
    chk("pre tgt", pre_i, tgt);
    wstat(STAT_FAULT, 300);
    repeat (50) @(posedge pclk);
    chk("held", STAT_FAULT, {sb, sa});
    dead_cell <= 1'b0;
    ctrl(32'h0);
    ctrl(32'h1);
    wstat(STAT_OFF, 4);
    wt("restart", chg, 1'b1, 100);
    wstat(STAT_FAULT, 300);
    ctrl(32'h0);
    ctrl(32'h5);
    wt("fast on", chg, 1'b1, 100);
    for (int i = 1; i <= SS_STEPS; i++) begin
      n = 0;
      while (tgt !== 8'((fast_i * i) / 8) && n < 40) begin
        @(posedge pclk);
        n++;
      end
      chk("step", 8'((fast_i * i) / 8), tgt);
    end
    wstat(STAT_DONE, 500);
    chk("done off", 0, chg);
    ctrl(32'h0);
    ctrl(32'h3);
    wt("low mode", chg, 1'b1, 100);
    repeat (300) @(posedge pclk);
    chk("no term", 1, chg);
    // Each stop input takes over from the last, so charging stays off until low_supply_state clears
    dot <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("hot stop", 0, chg);
    dot <= 1'b0;
    btf <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("cell temp", 0, chg);
    btf <= 1'b0;
    rgood <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("reg bad", 0, chg);
    rgood <= 1'b1;
    lss <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("low supply", 0, chg);
    lss <= 1'b0;
    wt("resume", chg, 1'b1, 100);
    ovp <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("ov stop", 0, chg);
    ovp <= 1'b0;
    lockout <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("lockout ac", 0, ac);
    chk("lockout bat", 1, bat);
    lockout <= 1'b0;
    wt("ac back", ac, 1'b1, 1400);
    plugged <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("ac hold", 1, ac);
    wt("bat back", bat, 1'b1, 1400);
    end_sim();
  end
endmodule : charge_sequencer_power_selector_test
